// ===== logic/timing_relay.sv
// Programmable timing relay with an AHB-Lite register slave.
//
// Function
// - Each setpoint selects a constant, four analog inputs, any timer or counter value; both of the last read the one OFF_EXTVAL register.
// - Nine modes: on, off, on/off delay with random variants, pulse, two flashes.
// - Seconds base spans 0 to 99.999 s in 1 ms steps.
// - Minutes-seconds base spans to 99:59 in 1 s steps.
// - Hours-minutes base spans to 99:59 in 1 min steps.
// - Expiry is only detected at a scan cycle boundary.
// - A variable source above the base maximum is clamped to that maximum.
// - Seconds base: variable value times ten gives milliseconds.
// - Minutes-seconds base: value over sixty gives minutes, remainder seconds.
// - Hours-minutes base: value over sixty gives hours, remainder minutes.
// - Only relays 7, 8 and 13 to 16 may be retentive, chosen by setting.
// - A retentive relay keeps its value over stop and resumes on run.
// - On-delay closes after the setpoint with trigger held; early drop abandons it.
// - Hold freezes timing; in on-delay hold does nothing after expiry.
// - On-delay clear zeroes time, opens contact; held trigger restarts timing after.
// - Off-delay follows trigger on, times after release, then opens.
// - Off-delay clear opens the contact even while timing; normal afterwards.
// - Off-delay retrigger during timing clears elapsed time for a full run.
// - Random variants switch after a random time within the setpoint.
`timescale 1ns/1ps
`default_nettype none
module timing_relay #(
   parameter int RELAY_INDEX = 7,
   parameter int SCAN_CYCLES = timing_relay_pkg::TICK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic contact
);
   import timing_relay_pkg::*;

   typedef enum logic [1:0] {IDLE, PHASE1, PHASE2, DONE} phase_e;

   logic [3:0] mode;
   logic [1:0] base;
   logic [16:0] sp_const1, sp_const2;
   logic [2:0] src1, src2;
   logic [3:0] ctrl;
   logic retain_en;
   logic [63:0] analog;
   logic [15:0] ext_value;
   logic [16:0] actual;
   logic [16:0] target;
   logic [15:0] lfsr;
   logic [31:0] scan_cnt;
   logic [15:0] unit_cnt;
   logic scan_tick;
   logic tick;
   phase_e phase;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [31:0] rd_word;

   // Bus decode: the slave is always ready, so one address phase is one transfer.
   wire bus_go = hsel & htrans[1] & hready;
   wire [7:0] word_addr = {haddr[7:2], 2'b00};
   wire run = ctrl[CTRL_RUN];
   wire trig = ctrl[CTRL_TRIGGER];
   wire hold = ctrl[CTRL_HOLD];
   wire clear = ctrl[CTRL_CLEAR];
   wire retentive = retain_en & RETAIN_MASK[RELAY_INDEX - 1];
   wire is_random = (mode == MODE_ON_RND) | (mode == MODE_OFF_RND) | (mode == MODE_ONOFF_RND);
   wire is_off = (mode == MODE_OFF) | (mode == MODE_OFF_RND);
   wire is_onoff = (mode == MODE_ONOFF) | (mode == MODE_ONOFF_RND);
   wire is_on = (mode == MODE_ON) | (mode == MODE_ON_RND);
   wire two_sp = (mode == MODE_ONOFF) | (mode == MODE_ONOFF_RND) | (mode == MODE_FLASH_SYM) |
                 (mode == MODE_FLASH_ASYM);

   // Variable source selection and conversion to the base's units.
   function automatic logic [16:0] pick(input logic [2:0] src, input logic [16:0] k, input logic [1:0] b,
                                        input logic [63:0] an, input logic [15:0] ev);
      logic [15:0] raw;
      logic [19:0] conv;
      logic [16:0] max;
      raw = 16'h0000;
      unique case (src)
         3'h1: raw = an[15:0];
         3'h2: raw = an[31:16];
         3'h3: raw = an[47:32];
         3'h4: raw = an[63:48];
         SRC_TIMER, SRC_COUNTER: raw = ev;
         default: raw = 16'h0000;
      endcase
      unique case (b)
         BASE_S: max = MAX_S;
         BASE_MS: max = MAX_MINSEC;
         default: max = MAX_HOURMIN;
      endcase
      // Holding the value in units of the finer field keeps minutes and seconds as quotient and remainder.
      // The product stays wide so that a large source is clamped rather than wrapped.
      if (b == BASE_S) begin
         conv = {4'h0, raw} * {3'h0, SCALE_S};
      end else begin
         conv = {4'h0, raw};
      end
      if (src == SRC_CONST) begin
         conv = {3'h0, k};
      end
      pick = (conv > {3'h0, max}) ? max : conv[16:0];
   endfunction

   wire [16:0] sp1 = pick(src1, sp_const1, base, analog, ext_value);
   wire [16:0] sp2 = (mode == MODE_FLASH_SYM) ? sp1 : pick(src2, sp_const2, base, analog, ext_value);
   // One scan unit per tick: ms, s or min depending on base.
   wire [15:0] unit_len = (base == BASE_S) ? 16'h0001 : ((base == BASE_MS) ? 16'h03E8 : 16'hEA60);
   wire [16:0] rnd_sp1 = (sp1 == 17'd0) ? 17'd0 : 17'({1'b0, lfsr} % {15'd0, sp1 + 17'd1});
   wire [16:0] rnd_sp2 = (sp2 == 17'd0) ? 17'd0 : 17'({1'b0, lfsr} % {15'd0, sp2 + 17'd1});
   wire [16:0] start1 = is_random ? rnd_sp1 : sp1;
   wire [16:0] start2 = is_random ? rnd_sp2 : sp2;
   wire expired = (actual >= target);

   // The scan pulse comes first, so the hour base never needs a cycle count beyond 32 bits.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_cnt <= 32'h0000_0000;
         scan_tick <= 1'b0;
      end else if (scan_cnt + 32'd1 >= 32'(SCAN_CYCLES)) begin
         scan_cnt <= 32'h0000_0000;
         scan_tick <= 1'b1;
      end else begin
         scan_cnt <= scan_cnt + 32'd1;
         scan_tick <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unit_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (scan_tick & (unit_cnt + 16'd1 >= unit_len)) begin
         unit_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         unit_cnt <= unit_cnt + {15'h0, scan_tick};
         tick <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfsr <= LFSR_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
   end

   // Bus write path, registered in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= bus_go & hwrite;
         wr_addr <= word_addr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= MODE_ON;
         base <= BASE_S;
         sp_const1 <= 17'd0;
         sp_const2 <= 17'd0;
         src1 <= SRC_CONST;
         src2 <= SRC_CONST;
         ctrl <= 4'h0;
         retain_en <= 1'b0;
         analog <= 64'h0;
         ext_value <= 16'h0000;
      end else if (wr_pend) begin
         unique case (wr_addr)
            OFF_MODE: mode <= hwdata[3:0];
            OFF_BASE: base <= hwdata[1:0];
            OFF_SP1: sp_const1 <= hwdata[16:0];
            OFF_SP2: sp_const2 <= hwdata[16:0];
            OFF_SRC1: src1 <= hwdata[2:0];
            OFF_SRC2: src2 <= hwdata[2:0];
            OFF_CTRL: ctrl <= hwdata[3:0];
            OFF_RETAIN: retain_en <= hwdata[0];
            OFF_ANALOG: analog <= {analog[47:0], hwdata[15:0]};
            OFF_EXTVAL: ext_value <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Timing engine: advances only on the base unit tick.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= IDLE;
         actual <= 17'd0;
         target <= 17'd0;
         contact <= 1'b0;
      end else if (tick) begin
         if (!run) begin
            // Stop mode: retentive relays keep their value, others drop it.
            contact <= 1'b0;
            if (!retentive) begin
               actual <= 17'd0;
               phase <= IDLE;
            end
         end else if (clear) begin
            actual <= 17'd0;
            phase <= IDLE;
            contact <= 1'b0;
         end else begin
            unique case (phase)
               IDLE: begin
                  if (trig & !is_off) begin
                     phase <= PHASE1;
                     target <= start1;
                     contact <= (mode == MODE_PULSE) | (mode == MODE_FLASH_SYM) | (mode == MODE_FLASH_ASYM);
                  end else if (trig) begin
                     contact <= 1'b1;
                     phase <= DONE;
                  end
               end
               PHASE1: begin
                  if (!trig & (is_on | mode == MODE_ONOFF | mode == MODE_ONOFF_RND |
                               mode == MODE_FLASH_SYM | mode == MODE_FLASH_ASYM)) begin
                     phase <= IDLE;
                     actual <= 17'd0;
                     contact <= 1'b0;
                  end else if (hold) begin
                     actual <= actual;
                  end else if (expired) begin
                     actual <= 17'd0;
                     if (mode == MODE_PULSE) begin
                        contact <= 1'b0;
                        phase <= DONE;
                     end else if (two_sp & (mode != MODE_ONOFF) & (mode != MODE_ONOFF_RND)) begin
                        contact <= 1'b0;
                        phase <= PHASE2;
                        target <= start2;
                     end else begin
                        contact <= 1'b1;
                        phase <= DONE;
                     end
                  end else begin
                     actual <= actual + 17'd1;
                  end
               end
               PHASE2: begin
                  if (!trig & !is_off & !is_onoff) begin
                     phase <= IDLE;
                     actual <= 17'd0;
                     contact <= 1'b0;
                  end else if ((is_off | is_onoff) & trig) begin
                     actual <= 17'd0;
                     phase <= DONE;
                  end else if (hold) begin
                     actual <= actual;
                  end else if (expired) begin
                     actual <= 17'd0;
                     if (is_off | mode == MODE_ONOFF | mode == MODE_ONOFF_RND) begin
                        contact <= 1'b0;
                        phase <= IDLE;
                     end else begin
                        contact <= 1'b1;
                        phase <= PHASE1;
                        target <= start1;
                     end
                  end else begin
                     actual <= actual + 17'd1;
                  end
               end
               DONE: begin
                  // Hold has no effect while the on-delay contact stands.
                  if (!trig & !is_on) begin
                     phase <= PHASE2;
                     target <= start2;
                     actual <= 17'd0;
                     if (is_off) begin
                        target <= start1;
                     end
                  end else if (!trig) begin
                     phase <= IDLE;
                     contact <= 1'b0;
                  end
               end
               default: phase <= IDLE;
            endcase
         end
      end
   end

   assign rd_word = (word_addr == OFF_MODE) ? {28'h0, mode} :
                    (word_addr == OFF_BASE) ? {30'h0, base} :
                    (word_addr == OFF_SP1) ? {15'h0, sp_const1} :
                    (word_addr == OFF_SP2) ? {15'h0, sp_const2} :
                    (word_addr == OFF_SRC1) ? {29'h0, src1} :
                    (word_addr == OFF_SRC2) ? {29'h0, src2} :
                    (word_addr == OFF_CTRL) ? {28'h0, ctrl} :
                    (word_addr == OFF_STATUS) ? {30'h0, phase != IDLE, contact} :
                    (word_addr == OFF_ACTUAL) ? {15'h0, actual} :
                    (word_addr == OFF_RETAIN) ? {30'h0, retentive, retain_en} :
                    (word_addr == OFF_EXTVAL) ? {16'h0, ext_value} :
                    32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_go & !hwrite) begin
         hrdata <= rd_word;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   clear_opens_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & run & clear) |=> !contact) else $error("Clear did not open the contact.");
   no_tick_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !tick |=> $stable(contact)) else $error("Contact changed off a scan boundary.");
   hold_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & run & !clear & hold & phase == PHASE1 & trig) |=> $stable(actual))
      else $error("Hold did not freeze time.");
   clamp_s_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (base == BASE_S) |-> sp1 <= MAX_S) else $error("Seconds setpoint not clamped.");
   clamp_ms_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (base != BASE_S) |-> sp1 <= MAX_MINSEC) else $error("Minute setpoint not clamped.");
   rand_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      is_random |-> start1 <= sp1) else $error("Random delay above setpoint.");
   on_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & run & !clear & is_on & phase == PHASE1 & !trig) |=> (!contact && phase == IDLE))
      else $error("On-delay not abandoned.");
   stop_retain_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & !run & retentive) |=> $stable(actual)) else $error("Retentive value lost.");
   off_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & run & !clear & is_off & phase == IDLE & trig) |=> contact)
      else $error("Off-delay contact did not follow trigger.");

   sequence scan_live;
      tick & run & !clear;
   endsequence
   clear_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & run & clear) |=> (actual == 17'd0 && phase == IDLE)) else $error("Clear did not zero the time.");
   retrig_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_live ##0 (is_off & phase == PHASE2 & trig) |=> (actual == 17'd0 && phase == DONE))
      else $error("Retrigger did not clear the off-delay.");
   off_expire_a: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_live ##0 (is_off & phase == PHASE2 & !trig & !hold & expired) |=> !contact)
      else $error("Off-delay contact did not open.");
   pulse_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_live ##0 (mode == MODE_PULSE & phase == PHASE1 & !hold & expired) |=> (!contact && phase == DONE))
      else $error("Pulse did not end once.");
   stop_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tick & !run) |=> !contact) else $error("Stop left the contact closed.");
endmodule
`default_nettype wire

// ===== logic/timing_relay_pkg.sv
// Constants, field layouts and enumerations for the programmable timing relay.
package timing_relay_pkg;
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_BASE = 8'h04;
   localparam logic [7:0] OFF_SP1 = 8'h08;
   localparam logic [7:0] OFF_SP2 = 8'h0C;
   localparam logic [7:0] OFF_SRC1 = 8'h10;
   localparam logic [7:0] OFF_SRC2 = 8'h14;
   localparam logic [7:0] OFF_CTRL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_ACTUAL = 8'h20;
   localparam logic [7:0] OFF_RETAIN = 8'h24;
   localparam logic [7:0] OFF_ANALOG = 8'h28;
   localparam logic [7:0] OFF_EXTVAL = 8'h2C;
   localparam logic [7:0] OFF_EXTSEL = 8'h30;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_TRIGGER = 1;
   localparam int CTRL_HOLD = 2;
   localparam int CTRL_CLEAR = 3;
   localparam int STAT_CONTACT = 0;
   localparam int STAT_TIMING = 1;
   localparam logic [3:0] MODE_ON = 4'h0;
   localparam logic [3:0] MODE_ON_RND = 4'h1;
   localparam logic [3:0] MODE_OFF = 4'h2;
   localparam logic [3:0] MODE_OFF_RND = 4'h3;
   localparam logic [3:0] MODE_ONOFF = 4'h4;
   localparam logic [3:0] MODE_ONOFF_RND = 4'h5;
   localparam logic [3:0] MODE_PULSE = 4'h6;
   localparam logic [3:0] MODE_FLASH_SYM = 4'h7;
   localparam logic [3:0] MODE_FLASH_ASYM = 4'h8;
   localparam logic [1:0] BASE_S = 2'h0;
   localparam logic [1:0] BASE_MS = 2'h1;
   localparam logic [1:0] BASE_HM = 2'h2;
   // Source select: 0 constant, 1..4 analog a..d, 5 timer value, 6 counter value.
   localparam logic [2:0] SRC_CONST = 3'h0;
   localparam logic [2:0] SRC_TIMER = 3'h5;
   localparam logic [2:0] SRC_COUNTER = 3'h6;
   localparam logic [16:0] MAX_S = 17'd99999;
   localparam logic [16:0] MAX_MINSEC = 17'd5999;
   localparam logic [16:0] MAX_HOURMIN = 17'd5999;
   localparam logic [16:0] SCALE_S = 17'd10;
   localparam logic [16:0] SIXTY = 17'd60;
   localparam int CLK_MHZ = 100;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [31:0] RETAIN_MASK = 32'h0000_F0C0;
endpackage

// ===== tb/coil_program.sv
// Bus master model of the user program that drives the relay coils.
`timescale 1ns/1ps
`default_nettype none
module coil_program (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic stuck
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      stuck = 1'b0;
   end
   // A slave that never answers must not hang the run, so the wait is bounded.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) stuck <= 1'b1;
   endtask
   // The trigger level held across a stop is whatever the caller last wrote, never changed here.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask
endmodule
`default_nettype wire

// ===== tb/programmable_timing_relay_test.sv
// Self-checking bench for the programmable timing relay.
`timescale 1ns/1ps
`default_nettype none
module programmable_timing_relay_test;
   import timing_relay_pkg::*;
   localparam int SCAN = 2;
   typedef struct {
      logic [3:0] mode; logic [1:0] base; logic [2:0] src; logic [16:0] sp; logic [31:0] ext;
      int lo; int hi; logic drop; logic pre; logic post; logic rnd;
   } row_s;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   wire logic hsel, hwrite, hreadyout, hresp, contact, stuck;
   wire logic [31:0] haddr, hwdata, hrdata;
   wire logic [1:0] htrans;
   wire logic [2:0] hsize;
   int n_fail = 0;
   int tests_run = 0;
   logic [31:0] rd;
   row_s rows [10];
   always #5 hclk = ~hclk;
   coil_program prog (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .stuck(stuck));
   timing_relay #(.RELAY_INDEX(7), .SCAN_CYCLES(SCAN)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .contact(contact));
   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t contact %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      prog.xfer(1'b1, a, d, q);
   endtask
   task automatic rg(input logic [7:0] a);
      prog.xfer(1'b0, a, 32'h0, rd);
   endtask
   // One scan tick is one millisecond in the seconds base.
   task automatic wait_ms(input int n);
      repeat (n * SCAN) @(posedge hclk);
   endtask
   task automatic setup(input logic [3:0] m, input logic [16:0] sp);
      wr(OFF_CTRL, 32'h9);
      wr(OFF_MODE, 32'(m));
      wr(OFF_BASE, 32'(BASE_S));
      wr(OFF_SRC1, 32'(SRC_CONST));
      wr(OFF_SP1, 32'(sp));
   endtask
   always @(posedge stuck) begin
      n_fail++;
      print_verdict();
   end
   initial begin
      rows[0] = '{MODE_ON, BASE_S, SRC_CONST, 17'd20, 32'h0, 17, 23, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[1] = '{MODE_ON, BASE_S, SRC_TIMER, 17'd0, 32'h3, 27, 33, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[2] = '{MODE_ON, BASE_S, SRC_COUNTER, 17'd0, 32'h2, 17, 23, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[3] = '{MODE_ON, BASE_MS, SRC_TIMER, 17'd0, 32'h2, 2900, 4100, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[4] = '{MODE_OFF, BASE_S, SRC_CONST, 17'd20, 32'h0, 17, 23, 1'b1, 1'b1, 1'b0, 1'b0};
      rows[5] = '{MODE_ON_RND, BASE_S, SRC_CONST, 17'd20, 32'h0, 0, 23, 1'b0, 1'b0, 1'b1, 1'b1};
      rows[6] = '{MODE_OFF_RND, BASE_S, SRC_CONST, 17'd20, 32'h0, 0, 23, 1'b1, 1'b1, 1'b0, 1'b1};
      rows[7] = '{MODE_PULSE, BASE_S, SRC_CONST, 17'd20, 32'h0, 17, 23, 1'b0, 1'b1, 1'b0, 1'b0};
      rows[8] = '{MODE_ONOFF, BASE_S, SRC_CONST, 17'd20, 32'h0, 17, 23, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[9] = '{MODE_FLASH_SYM, BASE_S, SRC_CONST, 17'd20, 32'h0, 17, 23, 1'b0, 1'b1, 1'b0, 1'b0};
      repeat (6) @(posedge hclk);
      chk_word({hrdata[31:2], hreadyout, hresp}, 32'h2);
      chk_bit(contact, 1'b0);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         wr(OFF_CTRL, 32'h9);
         wr(OFF_MODE, 32'(rows[i].mode));
         wr(OFF_BASE, 32'(rows[i].base));
         wr(OFF_SRC1, 32'(rows[i].src));
         wr(OFF_SP1, 32'(rows[i].sp));
         wr(OFF_EXTVAL, rows[i].ext);
         wr(OFF_CTRL, 32'h3);
         if (rows[i].drop) begin
            wait_ms(2);
            chk_bit(contact, 1'b1);
            wr(OFF_CTRL, 32'h1);
         end
         wait_ms(rows[i].lo);
         if (!rows[i].rnd) chk_bit(contact, rows[i].pre);
         wait_ms(rows[i].hi - rows[i].lo);
         chk_bit(contact, rows[i].post);
         rg(OFF_STATUS);
         chk_word(rd & 32'h1, 32'(rows[i].post));
      end
      rg(8'hF0);
      chk_word(rd, 32'h0);
      chk_word({30'h0, hreadyout, hresp}, 32'h2);
      setup(MODE_ON, 17'd20);
      wr(OFF_CTRL, 32'h3);
      wait_ms(5);
      wr(OFF_CTRL, 32'h7);
      wait_ms(40);
      chk_bit(contact, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wait_ms(10);
      chk_bit(contact, 1'b0);
      wait_ms(10);
      chk_bit(contact, 1'b1);
      wr(OFF_CTRL, 32'h7);
      wait_ms(5);
      chk_bit(contact, 1'b1);
      wr(OFF_CTRL, 32'h9);
      wr(OFF_CTRL, 32'h3);
      wait_ms(10);
      wr(OFF_CTRL, 32'hF);
      wait_ms(3);
      chk_bit(contact, 1'b0);
      rg(OFF_ACTUAL);
      chk_word(rd, 32'h0);
      wr(OFF_CTRL, 32'h3);
      wait_ms(17);
      chk_bit(contact, 1'b0);
      wait_ms(6);
      chk_bit(contact, 1'b1);
      wr(OFF_CTRL, 32'h9);
      wr(OFF_CTRL, 32'h3);
      wait_ms(10);
      wr(OFF_CTRL, 32'h1);
      wait_ms(30);
      chk_bit(contact, 1'b0);
      setup(MODE_OFF, 17'd20);
      wr(OFF_CTRL, 32'h3);
      wr(OFF_CTRL, 32'h1);
      wait_ms(12);
      wr(OFF_CTRL, 32'h3);
      wait_ms(2);
      wr(OFF_CTRL, 32'h1);
      wait_ms(15);
      chk_bit(contact, 1'b1);
      wait_ms(8);
      chk_bit(contact, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wr(OFF_CTRL, 32'h1);
      wait_ms(5);
      wr(OFF_CTRL, 32'h9);
      wait_ms(2);
      chk_bit(contact, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wait_ms(3);
      chk_bit(contact, 1'b1);
      wr(OFF_RETAIN, 32'h1);
      rg(OFF_RETAIN);
      chk_word(rd & 32'h3, 32'h3);
      setup(MODE_ON, 17'd20);
      wr(OFF_CTRL, 32'h3);
      wait_ms(12);
      wr(OFF_CTRL, 32'h2);
      wait_ms(30);
      chk_bit(contact, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wait_ms(12);
      chk_bit(contact, 1'b1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk_bit(contact, 1'b0);
      chk_word({hrdata[29:0], hreadyout, hresp}, 32'h2);
      hresetn <= 1'b1;
      @(posedge hclk);
      rg(OFF_CTRL);
      chk_word(rd, 32'h0);
      rg(OFF_RETAIN);
      chk_word(rd, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
